// ==== rtl/pdb_top.sv ====
// Peripheral disable bank with its Avalon-MM slave and per-peripheral off lines.
`timescale 1ns/100ps
module pdb_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [pdb_pkg::PDB_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port change logic
  output logic change_notify_off_o,
  // Timers and signal measure
  output logic [pdb_pkg::PDB_TIMER_N-1:0] timer_n_off_o,
  output logic signal_measure_off_o,
  // Oscillator and analog
  output logic freq_osc_off_o,
  output logic dac_off_o,
  output logic adc_off_o,
  output logic comparator_two_off_o,
  output logic comparator_one_off_o,
  output logic zero_cross_off_o,
  // Pulse, capture and waveform
  output logic pwm_seven_off_o,
  output logic pwm_six_off_o,
  output logic [pdb_pkg::PDB_CAPTURE_N-1:0] capture_unit_off_o,
  output logic waveform_gen_two_off_o,
  output logic waveform_gen_one_off_o,
  // Serial
  output logic serial_transceiver_off_o,
  output logic sync_serial_off_o,
  // Logic cells and modulator
  output logic [pdb_pkg::PDB_LOGIC_CELL_N-1:0] logic_cell_n_off_o,
  output logic modulator_off_o
);
  import pdb_pkg::*;

  pdb_bank_if bank ();

  pdb_reg_bank u_bank (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .bus (bank.bank)
  );

  // Address decode.
  logic [PDB_IDX_W-1:0] idx;
  logic [PDB_IDX_W-1:0] rel;
  logic [PDB_SLOT_W-1:0] slot;
  logic hit;
  logic req;

  assign idx = avs_address_i[PDB_ADDR_W-1:2];
  assign rel = idx - PDB_IDX_BASE;
  assign slot = rel[PDB_SLOT_W-1:0];
  // Unaligned or out-of-range addresses read zero and drop writes.
  assign hit = (avs_address_i[1:0] == 2'h0) && (rel < PDB_IDX_W'(PDB_NUM_REGS));
  assign req = avs_read_i | avs_write_i;

  // Slave state: every access stalls one cycle, then completes.
  pdb_bus_e state_q;
  pdb_bus_e state_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [PDB_NUM_REGS-1:0] wr_sel;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    rdata_d = rdata_q;
    wr_sel = '0;
    case (state_q)
      PDB_BUS_IDLE: begin
        if (req) begin
          state_d = PDB_BUS_ACK;
          wait_d = 1'b0;
          rdata_d = 32'h0000_0000;
          if (avs_read_i && hit) begin
            rdata_d = {24'h00_0000, bank.value[slot]};
          end
        end
      end
      PDB_BUS_ACK: begin
        // The write lands on the edge where the master sees waitrequest low.
        state_d = PDB_BUS_IDLE;
        wait_d = 1'b1;
        if (avs_write_i && hit && avs_byteenable_i[PDB_DATA_LANE]) begin
          wr_sel[slot] = 1'b1;
        end
      end
      default: begin
        state_d = PDB_BUS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= PDB_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign bank.wr_sel = wr_sel;
  assign bank.wdata = avs_writedata_i[7:0];
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // Off lines come straight from the storage flip-flops.
  assign change_notify_off_o =
    bank.value[PDB_SLOT_CHANGE_NOTIFY][PDB_CHANGE_NOTIFY_BIT];
  assign timer_n_off_o =
    bank.value[PDB_SLOT_TIMER][PDB_TIMER_LSB +: PDB_TIMER_N];
  assign freq_osc_off_o = bank.value[PDB_SLOT_OSCILLATOR][PDB_FREQ_OSC_BIT];
  assign dac_off_o = bank.value[PDB_SLOT_ANALOG][PDB_DAC_BIT];
  assign adc_off_o = bank.value[PDB_SLOT_ANALOG][PDB_ADC_BIT];
  assign comparator_two_off_o = bank.value[PDB_SLOT_ANALOG][PDB_COMP_TWO_BIT];
  assign comparator_one_off_o = bank.value[PDB_SLOT_ANALOG][PDB_COMP_ONE_BIT];
  assign zero_cross_off_o = bank.value[PDB_SLOT_ANALOG][PDB_ZERO_CROSS_BIT];
  assign pwm_seven_off_o = bank.value[PDB_SLOT_PWM_CAPTURE][PDB_PWM_SEVEN_BIT];
  assign pwm_six_off_o = bank.value[PDB_SLOT_PWM_CAPTURE][PDB_PWM_SIX_BIT];
  assign capture_unit_off_o =
    bank.value[PDB_SLOT_PWM_CAPTURE][PDB_CAPTURE_LSB +: PDB_CAPTURE_N];
  assign waveform_gen_two_off_o =
    bank.value[PDB_SLOT_WAVEFORM_GEN][PDB_WAVE_TWO_BIT];
  assign waveform_gen_one_off_o =
    bank.value[PDB_SLOT_WAVEFORM_GEN][PDB_WAVE_ONE_BIT];
  assign serial_transceiver_off_o =
    bank.value[PDB_SLOT_SERIAL][PDB_SERIAL_XCVR_BIT];
  assign sync_serial_off_o = bank.value[PDB_SLOT_SERIAL][PDB_SYNC_SERIAL_BIT];
  assign signal_measure_off_o =
    bank.value[PDB_SLOT_LOGIC_MEASURE][PDB_SIGNAL_MEASURE_BIT];
  assign logic_cell_n_off_o =
    bank.value[PDB_SLOT_LOGIC_MEASURE][PDB_LOGIC_CELL_LSB +: PDB_LOGIC_CELL_N];
  assign modulator_off_o =
    bank.value[PDB_SLOT_LOGIC_MEASURE][PDB_MODULATOR_BIT];

endmodule : pdb_top

// ==== rtl/pdb_pkg.sv ====
// Package of constants and types for the peripheral disable register bank.
package pdb_pkg;

  typedef logic [7:0] pdb_byte_t;

  // Bus geometry: each register index occupies one aligned 32-bit word.
  localparam int unsigned PDB_ADDR_W = 14;
  localparam int unsigned PDB_IDX_W = 12;
  localparam int unsigned PDB_NUM_REGS = 8;
  localparam int unsigned PDB_SLOT_W = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_BASE = 12'h796;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_CHANGE_NOTIFY = 12'h796;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_TIMER = 12'h797;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_OSCILLATOR = 12'h798;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_ANALOG = 12'h799;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_PWM_CAPTURE = 12'h79A;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_WAVEFORM_GEN = 12'h79B;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_SERIAL = 12'h79C;
  localparam logic [PDB_IDX_W-1:0] PDB_IDX_LOGIC_MEASURE = 12'h79D;

  // Slot numbers inside the bank, in index order.
  localparam int unsigned PDB_SLOT_CHANGE_NOTIFY = 0;
  localparam int unsigned PDB_SLOT_TIMER = 1;
  localparam int unsigned PDB_SLOT_OSCILLATOR = 2;
  localparam int unsigned PDB_SLOT_ANALOG = 3;
  localparam int unsigned PDB_SLOT_PWM_CAPTURE = 4;
  localparam int unsigned PDB_SLOT_WAVEFORM_GEN = 5;
  localparam int unsigned PDB_SLOT_SERIAL = 6;
  localparam int unsigned PDB_SLOT_LOGIC_MEASURE = 7;

  // Field positions.
  localparam int unsigned PDB_CHANGE_NOTIFY_BIT = 0;
  localparam int unsigned PDB_TIMER_LSB = 0;
  localparam int unsigned PDB_TIMER_N = 7;
  localparam int unsigned PDB_FREQ_OSC_BIT = 7;
  localparam int unsigned PDB_DAC_BIT = 6;
  localparam int unsigned PDB_ADC_BIT = 5;
  localparam int unsigned PDB_COMP_TWO_BIT = 2;
  localparam int unsigned PDB_COMP_ONE_BIT = 1;
  localparam int unsigned PDB_ZERO_CROSS_BIT = 0;
  localparam int unsigned PDB_PWM_SEVEN_BIT = 6;
  localparam int unsigned PDB_PWM_SIX_BIT = 5;
  localparam int unsigned PDB_CAPTURE_LSB = 0;
  localparam int unsigned PDB_CAPTURE_N = 4;
  localparam int unsigned PDB_WAVE_TWO_BIT = 6;
  localparam int unsigned PDB_WAVE_ONE_BIT = 5;
  localparam int unsigned PDB_SERIAL_XCVR_BIT = 4;
  localparam int unsigned PDB_SYNC_SERIAL_BIT = 0;
  localparam int unsigned PDB_SIGNAL_MEASURE_BIT = 5;
  localparam int unsigned PDB_LOGIC_CELL_LSB = 1;
  localparam int unsigned PDB_LOGIC_CELL_N = 4;
  localparam int unsigned PDB_MODULATOR_BIT = 0;

  // Implemented-bit masks and reset values per slot.
  localparam pdb_byte_t PDB_MASK [PDB_NUM_REGS] = '{
    8'h01, 8'h7F, 8'h80, 8'h67, 8'h6F, 8'h60, 8'h11, 8'h3F
  };
  localparam pdb_byte_t PDB_RESET [PDB_NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // Byte lane that carries the 8-bit register data.
  localparam int unsigned PDB_DATA_LANE = 0;

  typedef enum logic [0:0] {
    PDB_BUS_IDLE = 1'b0,
    PDB_BUS_ACK = 1'b1
  } pdb_bus_e;

endpackage : pdb_pkg

// ==== rtl/pdb_bank_if.sv ====
// Interface between the bus slave and the register storage.
`timescale 1ns/100ps
interface pdb_bank_if;
  import pdb_pkg::*;

  pdb_byte_t wdata;
  logic [PDB_NUM_REGS-1:0] wr_sel;
  pdb_byte_t value [PDB_NUM_REGS];

  modport bank (input wdata, input wr_sel, output value);
  modport ctrl (output wdata, output wr_sel, input value);
endinterface : pdb_bank_if

// ==== rtl/pdb_reg_bank.sv ====
// Storage flip-flops of the disable registers, one masked byte per slot.
`timescale 1ns/100ps
module pdb_reg_bank (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bank access
  pdb_bank_if.bank bus
);
  import pdb_pkg::*;

  for (genvar i = 0; i < PDB_NUM_REGS; i++) begin : g_reg
    pdb_byte_t value_q;
    pdb_byte_t value_d;

    // Masking at the write keeps unimplemented bits at zero forever.
    always_comb begin
      value_d = value_q;
      if (bus.wr_sel[i]) begin
        value_d = bus.wdata & PDB_MASK[i];
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        value_q <= PDB_RESET[i];
      end else begin
        value_q <= value_d;
      end
    end

    assign bus.value[i] = value_q;
  end

endmodule : pdb_reg_bank

// ==== bench/pdb_top_props.sv ====
// Assertion checker for the disable bank bus handshake and off lines.
`timescale 1ns/100ps
module pdb_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus
  input wire logic [pdb_pkg::PDB_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Off lines
  input wire logic change_notify_off_o,
  input wire logic [pdb_pkg::PDB_TIMER_N-1:0] timer_n_off_o,
  input wire logic freq_osc_off_o,
  input wire logic [pdb_pkg::PDB_LOGIC_CELL_N-1:0] logic_cell_n_off_o,
  input wire logic modulator_off_o
);
  logic wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_wait_one_cycle: assert property (
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_req_answered: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_notify_write: assert property (
    wr_ok && avs_address_i == 14'h1E58
    |=> change_notify_off_o == $past(avs_writedata_i[0]))
    else $error("change notify line not loaded");
  a_timer_write: assert property (
    wr_ok && avs_address_i == 14'h1E5C
    |=> timer_n_off_o == $past(avs_writedata_i[6:0]))
    else $error("timer lines not loaded");
  a_osc_write: assert property (
    wr_ok && avs_address_i == 14'h1E60
    |=> freq_osc_off_o == $past(avs_writedata_i[7]))
    else $error("oscillator line not loaded");
  a_cells_write: assert property (
    wr_ok && avs_address_i == 14'h1E74
    |=> {logic_cell_n_off_o, modulator_off_o} == $past(avs_writedata_i[4:0]))
    else $error("logic cell lines not loaded");
  a_off_hold: assert property (
    !wr_ok |=> $stable({change_notify_off_o, timer_n_off_o, freq_osc_off_o,
      logic_cell_n_off_o, modulator_off_o}))
    else $error("off line moved without a write");
  a_upper_zero: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_read_timer: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == 14'h1E5C
    |-> avs_readdata_o[7:0] == {1'b0, timer_n_off_o})
    else $error("timer read differs from lines");
endmodule : pdb_props

bind pdb_top pdb_props pdb_props_i (.*);

// ==== bench/tb_pdb_top.sv ====
// Self-checking bench for the peripheral disable bank.
`timescale 1ns/100ps
module tb_pdb_top;
  import pdb_pkg::*;
  localparam pdb_byte_t MSK [8] = '{8'h01, 8'h7F, 8'h80, 8'h67, 8'h6F, 8'h60, 8'h11, 8'h3F};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [PDB_ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, change_notify_off_o, signal_measure_off_o, freq_osc_off_o, dac_off_o;
  logic adc_off_o, comparator_two_off_o, comparator_one_off_o, zero_cross_off_o, pwm_seven_off_o;
  logic pwm_six_off_o, waveform_gen_two_off_o, waveform_gen_one_off_o, serial_transceiver_off_o;
  logic sync_serial_off_o, modulator_off_o;
  logic [6:0] timer_n_off_o;
  logic [3:0] capture_unit_off_o, logic_cell_n_off_o;
  logic [31:0] offs;
  pdb_byte_t regs [8] = '{default: 8'h00};
  int err_total = 0;
  int num_checks = 0;
  always #50 mclk_i = ~mclk_i;
  assign offs = {2'h0, change_notify_off_o, timer_n_off_o, freq_osc_off_o, dac_off_o, adc_off_o,
    comparator_two_off_o, comparator_one_off_o, zero_cross_off_o, pwm_seven_off_o, pwm_six_off_o,
    capture_unit_off_o, waveform_gen_two_off_o, waveform_gen_one_off_o, serial_transceiver_off_o,
    sync_serial_off_o, signal_measure_off_o, logic_cell_n_off_o, modulator_off_o};
  pdb_top pdb_top_i (.*);

  function automatic logic [31:0] exp_off();
    return {2'h0, regs[0][0], regs[1][6:0], regs[2][7], regs[3][6:5], regs[3][2:0], regs[4][6:5],
      regs[4][3:0], regs[5][6:5], regs[6][4], regs[6][0], regs[7][5:0]};
  endfunction : exp_off

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One request held until waitrequest is sampled low, then one idle cycle.
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d,
      input logic [3:0] b, output logic [31:0] q);
    int n;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= b;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    // Software leaves a gap after every access, re-enabling writes included.
    @(posedge mclk_i);
  endtask : bus

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    regs = '{default: 8'h00};
  endtask : do_reset

  task automatic t_reset_vals();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 14'h1E58 + 14'(4 * i), 8'h00, 4'h1, q);
      chk("reset value", q, 32'h0);
    end
    chk("off lines at reset", offs, 32'h0);
  endtask : t_reset_vals

  // A single walking one catches swapped or stuck lines.
  task automatic t_walk();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < 8; b++) begin
        bus(1'b1, 14'h1E58 + 14'(4 * i), 8'h01 << b, 4'h1, q);
        regs[i] = MSK[i] & (8'h01 << b);
        bus(1'b0, 14'h1E58 + 14'(4 * i), 8'h00, 4'h0, q);
        chk("readback", q, {24'h0, regs[i]});
        chk("off lines", offs, exp_off());
      end
      bus(1'b1, 14'h1E58 + 14'(4 * i), 8'h00, 4'h1, q);
      regs[i] = 8'h00;
    end
  endtask : t_walk

  task automatic t_refused();
    logic [31:0] q;
    logic [13:0] bad [3] = '{14'h1E54, 14'h1E78, 14'h1E5D};
    bus(1'b1, 14'h1E5C, 8'hFF, 4'hE, q);
    foreach (bad[k]) begin
      bus(1'b1, bad[k], 8'hFF, 4'hF, q);
      bus(1'b0, bad[k], 8'h00, 4'hF, q);
      chk("unmapped read", q, 32'h0);
    end
    chk("off lines after refused writes", offs, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 14'h1E58 + 14'(4 * i), 8'hFF, 4'h1, q);
    end
  endtask : t_refused

  initial begin
    do_reset();
    t_reset_vals();
    t_walk();
    t_refused();
    do_reset();
    t_reset_vals();
    end_sim();
  end
endmodule : tb_pdb_top
